// file: hw/ctm_pkg.sv
// package: register map, field layout and codes of the compact timer
package ctm_pkg;
    // byte addresses of the registers on the bus
    localparam logic [7:0] OFF_PIN_ROUTE = 8'h00;
    localparam logic [7:0] OFF_CTRL0 = 8'h04;
    localparam logic [7:0] OFF_CTRL1 = 8'h08;
    localparam logic [7:0] OFF_CNT_LO = 8'h0c;
    localparam logic [7:0] OFF_CNT_HI = 8'h10;
    localparam logic [7:0] OFF_CMPA_LO = 8'h14;
    localparam logic [7:0] OFF_CMPA_HI = 8'h18;
    localparam logic [7:0] OFF_PERIOD = 8'h1c;
    localparam logic [7:0] OFF_FLAGS = 8'h20;
    // control register zero fields
    localparam int C0_PAUSE = 7;
    localparam int C0_CSEL_LO = 4;
    localparam int C0_ON = 3;
    // control register one fields
    localparam int C1_MODE_LO = 6;
    localparam int C1_IO_LO = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_DPX = 1;
    localparam int C1_CCLR = 0;
    // flag register fields
    localparam int FL_A = 0;
    localparam int FL_P = 1;
    // pin route width and reset values
    localparam int ROUTE_W = 5;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
    // clock select codes
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB = 3'h4;
    localparam logic [2:0] CK_RSV = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    // prescaler masks, all ones marks a divided tick
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0f;
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    // operating modes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_UNDEF = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    // output function codes
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
endpackage

// file: hw/ctm_top.sv
// module: compact 16-bit timer with wishbone register slave
// Behaviour
// - three-bit select picks clock; 101 disconnects
// - external pin counts rising or falling edges
// - external pin reaches timer only when selected
// - separate request lines for comparator A, P
// - compare match sets, clears or toggles output
// - output pin carries pwm waveform in pwm mode with output code 10
// - route bits hand pins to timer functions
// - compare low write only fills buffer
// - high write stores byte, loads buffered low
// - high read captures low byte into buffer
// - low read returns the buffer
// - sixteen-bit counter counts up on active edge
// - P matches high byte, A all bits
// - software only clears counter via on rise
// - counter clears on overflow or selected match
// - count read-only, compare registers read/write
// - compare output, timer/counter, pwm modes
// - pause freezes counter, clearing resumes it
// - on rise zeroes counter, off keeps value
// - code 110 rising, 111 falling pin edges
// - mode field 00 compare, 10 pwm, 11 timer
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ctm_top #(
    parameter int UNIT = 0 // which compact route bit drives this pin enable
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer_ext_clock_pin_i,
    input wire logic sub_clock_tick_i,
    output logic ext_pin_claimed_o,
    output logic timer_output_pin_o,
    output logic timer_output_oe_o,
    output logic [ctm_pkg::ROUTE_W-1:0] pin_route_o,
    output logic irq_a_o,
    output logic irq_p_o
);
    // software state
    logic [ctm_pkg::ROUTE_W-1:0] route_reg; // pin route bits
    logic pause_reg; // counter pause
    logic [2:0] csel_reg; // clock select
    logic on_reg; // timer on
    logic on_prev_reg; // on bit one cycle ago
    logic [1:0] mode_reg; // operating mode
    logic [1:0] io_reg; // output function
    logic oc_reg; // initial / active level
    logic pol_reg; // output inversion
    logic dpx_reg; // swap period and duty
    logic cclr_reg; // clear on A when set
    logic [7:0] period_reg; // comparator P value
    logic [15:0] cmpa_reg; // comparator A value
    logic [7:0] abuf_reg; // compare pair buffer
    logic [7:0] dbuf_reg; // count pair buffer
    // timer state
    logic [15:0] count_reg;
    logic [5:0] div_reg; // free-running prescaler
    logic ext_prev_reg; // pin level last cycle
    logic lvl_reg; // compare-mode output level
    logic flag_a_reg;
    logic flag_p_reg;
    // bus and pin output state
    logic ack_reg;
    logic [31:0] dat_reg;
    logic out_reg;
    logic oe_reg;
    logic claim_reg;

    // bus request decode, one per request
    logic take;
    logic wr;
    logic rd;
    assign take = cyc_i & stb_i & ~ack_reg;
    assign wr = take & we_i & sel_i[0];
    assign rd = take & ~we_i;

    // clock source decode
    logic sel_ext;
    logic ext_edge;
    logic tick;
    assign sel_ext = (csel_reg == ctm_pkg::CK_EXT_RISE) | (csel_reg == ctm_pkg::CK_EXT_FALL);
    // edge seen only while an external code (110 or 111) is selected; input is synchronous
    assign ext_edge = sel_ext & (timer_ext_clock_pin_i != ext_prev_reg) &
        (timer_ext_clock_pin_i == (csel_reg == ctm_pkg::CK_EXT_RISE));

    always_comb begin
        unique case (csel_reg)
            ctm_pkg::CK_SYS4: tick = (div_reg & ctm_pkg::DIV4_MASK) == ctm_pkg::DIV4_MASK;
            ctm_pkg::CK_SYS: tick = 1'b1;
            ctm_pkg::CK_H16: tick = (div_reg & ctm_pkg::DIV16_MASK) == ctm_pkg::DIV16_MASK;
            ctm_pkg::CK_H64: tick = div_reg == ctm_pkg::DIV64_MASK;
            ctm_pkg::CK_SUB: tick = sub_clock_tick_i;
            ctm_pkg::CK_RSV: tick = 1'b0; // disconnected source
            default: tick = ext_edge;
        endcase
    end

    // counting and match terms
    logic on_rise;
    logic run;
    logic [15:0] inc;
    logic am;
    logic pm;
    logic a_hit;
    logic p_hit;
    logic clr_hit;
    logic [15:0] duty;
    logic pwm_act;
    assign on_rise = on_reg & ~on_prev_reg;
    assign run = on_reg & ~pause_reg & tick & ~on_rise;
    assign inc = count_reg + 16'h0001;
    assign am = inc == cmpa_reg;
    // zero period means the match is the overflow itself
    assign pm = (period_reg == ctm_pkg::BYTE_RST) ? (count_reg == ctm_pkg::WORD_MAX) :
        ((inc[15:8] == period_reg) && (inc[7:0] == ctm_pkg::BYTE_RST));
    assign a_hit = run & am;
    assign p_hit = run & pm;
    // pwm ignores the clear select: the period comparator clears, or comparator A when the swap bit is set
    assign clr_hit = (mode_reg == ctm_pkg::MODE_PWM) ? (dpx_reg ? a_hit : p_hit) :
        (cclr_reg ? a_hit : p_hit);
    assign duty = dpx_reg ? {period_reg, ctm_pkg::BYTE_RST} : cmpa_reg;
    assign pwm_act = count_reg < duty;

    // prescaler and pin history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 6'h00;
            ext_prev_reg <= 1'b0;
            on_prev_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 6'h01;
            ext_prev_reg <= timer_ext_clock_pin_i;
            on_prev_reg <= on_reg;
        end
    end

    // main counter, no software load path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= ctm_pkg::WORD_RST;
        end else if (on_rise) begin
            count_reg <= ctm_pkg::WORD_RST;
        end else if (run) begin
            count_reg <= clr_hit ? ctm_pkg::WORD_RST : inc;
        end
    end

    // sticky match flags, set beats a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_a_reg <= 1'b0;
            flag_p_reg <= 1'b0;
        end else begin
            flag_a_reg <= a_hit | (flag_a_reg & ~(wr && adr_i == ctm_pkg::OFF_FLAGS && dat_i[ctm_pkg::FL_A]));
            flag_p_reg <= p_hit | (flag_p_reg & ~(wr && adr_i == ctm_pkg::OFF_FLAGS && dat_i[ctm_pkg::FL_P]));
        end
    end

    // compare-mode level; reloaded from the initial level on every on rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_reg <= 1'b0;
        end else if (on_rise) begin
            lvl_reg <= oc_reg;
        end else if (mode_reg == ctm_pkg::MODE_CMP && a_hit) begin
            unique case (io_reg)
                ctm_pkg::IO_NONE: lvl_reg <= lvl_reg;
                ctm_pkg::IO_LOW: lvl_reg <= 1'b0;
                ctm_pkg::IO_HIGH: lvl_reg <= 1'b1;
                ctm_pkg::IO_TOGGLE: lvl_reg <= ~lvl_reg;
            endcase
        end
    end

    // pin drive per mode; timer/counter and undefined modes hold it low
    logic pin_next;
    always_comb begin
        unique case (mode_reg)
            ctm_pkg::MODE_CMP: pin_next = lvl_reg ^ pol_reg;
            ctm_pkg::MODE_PWM: begin
                unique case (io_reg)
                    ctm_pkg::IO_LOW: pin_next = oc_reg ^ pol_reg;
                    ctm_pkg::IO_HIGH: pin_next = (pwm_act ? oc_reg : ~oc_reg) ^ pol_reg;
                    default: pin_next = ~oc_reg ^ pol_reg;
                endcase
            end
            default: pin_next = 1'b0;
        endcase
    end

    // registered pin outputs; a one-cycle lag is accepted for clean edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
            claim_reg <= 1'b0;
        end else begin
            out_reg <= pin_next;
            oe_reg <= route_reg[UNIT];
            claim_reg <= sel_ext;
        end
    end

    // control register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_reg <= '0;
            {pause_reg, csel_reg, on_reg} <= 5'h00;
            {mode_reg, io_reg, oc_reg, pol_reg, dpx_reg, cclr_reg} <= ctm_pkg::BYTE_RST;
            period_reg <= ctm_pkg::BYTE_RST;
        end else if (wr) begin
            unique case (adr_i)
                ctm_pkg::OFF_PIN_ROUTE: route_reg <= dat_i[ctm_pkg::ROUTE_W-1:0];
                ctm_pkg::OFF_CTRL0: begin
                    pause_reg <= dat_i[ctm_pkg::C0_PAUSE];
                    csel_reg <= dat_i[ctm_pkg::C0_CSEL_LO +: 3];
                    on_reg <= dat_i[ctm_pkg::C0_ON];
                end
                ctm_pkg::OFF_CTRL1: begin
                    mode_reg <= dat_i[ctm_pkg::C1_MODE_LO +: 2];
                    io_reg <= dat_i[ctm_pkg::C1_IO_LO +: 2];
                    oc_reg <= dat_i[ctm_pkg::C1_OC];
                    pol_reg <= dat_i[ctm_pkg::C1_POL];
                    dpx_reg <= dat_i[ctm_pkg::C1_DPX];
                    cclr_reg <= dat_i[ctm_pkg::C1_CCLR];
                end
                ctm_pkg::OFF_PERIOD: period_reg <= dat_i[7:0];
                default: ; // other offsets have no control bits
            endcase
        end
    end

    // compare pair and its buffer; order mistakes are the user's problem
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmpa_reg <= ctm_pkg::WORD_RST;
            abuf_reg <= ctm_pkg::BYTE_RST;
        end else if (wr && adr_i == ctm_pkg::OFF_CMPA_LO) begin
            abuf_reg <= dat_i[7:0];
        end else if (wr && adr_i == ctm_pkg::OFF_CMPA_HI) begin
            cmpa_reg <= {dat_i[7:0], abuf_reg};
        end else if (rd && adr_i == ctm_pkg::OFF_CMPA_HI) begin
            abuf_reg <= cmpa_reg[7:0];
        end
    end

    // count pair buffer, loaded only by a high read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbuf_reg <= ctm_pkg::BYTE_RST;
        end else if (rd && adr_i == ctm_pkg::OFF_CNT_HI) begin
            dbuf_reg <= count_reg[7:0];
        end
    end

    // read mux; unmapped reads answer zero
    logic [7:0] rbyte;
    always_comb begin
        unique case (adr_i)
            ctm_pkg::OFF_PIN_ROUTE: rbyte = {3'h0, route_reg};
            ctm_pkg::OFF_CTRL0: rbyte = {pause_reg, csel_reg, on_reg, 3'h0};
            ctm_pkg::OFF_CTRL1: rbyte = {mode_reg, io_reg, oc_reg, pol_reg, dpx_reg, cclr_reg};
            ctm_pkg::OFF_CNT_LO: rbyte = dbuf_reg;
            ctm_pkg::OFF_CNT_HI: rbyte = count_reg[15:8];
            ctm_pkg::OFF_CMPA_LO: rbyte = abuf_reg;
            ctm_pkg::OFF_CMPA_HI: rbyte = cmpa_reg[15:8];
            ctm_pkg::OFF_PERIOD: rbyte = period_reg;
            ctm_pkg::OFF_FLAGS: rbyte = {6'h00, flag_p_reg, flag_a_reg};
            default: rbyte = ctm_pkg::BYTE_RST;
        endcase
    end

    // one-cycle answer, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= ctm_pkg::BUS_ZERO;
        end else begin
            ack_reg <= take;
            if (rd) begin
                dat_reg <= {24'h00_0000, rbyte};
            end
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign ext_pin_claimed_o = claim_reg;
    assign timer_output_pin_o = out_reg;
    assign timer_output_oe_o = oe_reg;
    assign pin_route_o = route_reg;
    assign irq_a_o = flag_a_reg;
    assign irq_p_o = flag_p_reg;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    on_clear_a: assert property ($rose(on_reg) |=> count_reg == ctm_pkg::WORD_RST)
        else $error("counter not zeroed on on rise");
    pause_hold_a: assert property (pause_reg && !on_rise |=> $stable(count_reg))
        else $error("counter moved while paused");
    off_hold_a: assert property (!on_reg ##1 !on_reg |-> $stable(count_reg))
        else $error("counter moved while off");
    rsv_clock_a: assert property (csel_reg == ctm_pkg::CK_RSV && !on_rise |=> $stable(count_reg))
        else $error("reserved clock advanced counter");
    flag_a_set_a: assert property (a_hit |=> flag_a_reg && irq_a_o)
        else $error("A match flag missing");
    flag_p_set_a: assert property (p_hit |=> irq_p_o ##1 irq_p_o || $past(wr))
        else $error("P match flag missing");
    low_write_a: assert property (wr && adr_i == ctm_pkg::OFF_CMPA_LO |=> $stable(cmpa_reg))
        else $error("low write changed compare");
    high_write_a: assert property (wr && adr_i == ctm_pkg::OFF_CMPA_HI
        |=> cmpa_reg == {$past(dat_i[7:0]), $past(abuf_reg)})
        else $error("high write did not join buffer");
    high_read_a: assert property (rd && adr_i == ctm_pkg::OFF_CNT_HI
        |=> dbuf_reg == $past(count_reg[7:0]) ##1 !ack_o)
        else $error("high read did not capture low byte");
    low_read_a: assert property (rd && adr_i == ctm_pkg::OFF_CNT_LO |=> dat_o[7:0] == $past(dbuf_reg))
        else $error("low read not from buffer");
    toggle_out_a: assert property (mode_reg == ctm_pkg::MODE_CMP && io_reg == ctm_pkg::IO_TOGGLE
        && a_hit |=> lvl_reg != $past(lvl_reg))
        else $error("toggle did not flip level");
    // undefined mode must never leak a level onto the pin
    undef_pin_a: assert property (mode_reg == ctm_pkg::MODE_UNDEF |=> !timer_output_pin_o)
        else $error("undefined mode drove the pin");
    claim_drop_a: assert property (!sel_ext |=> !ext_pin_claimed_o)
        else $error("pin claimed without external select");

    pwm_cycle_c: cover property (mode_reg == ctm_pkg::MODE_PWM && clr_hit);
    ext_count_c: cover property (sel_ext && run);
    flag_clear_c: cover property (flag_a_reg ##1 !flag_a_reg);
    sub_clock_c: cover property (csel_reg == ctm_pkg::CK_SUB && run);
endmodule // ctm_top

// file: verif/ctm_pin_partner.sv
// pin-side partner of the compact timer: event source, sub clock tick, output pin load
`timescale 1ns/1ps
module ctm_pin_partner (
    input wire logic clk_i,
    input wire logic pin_drive_i, // timer output level
    input wire logic pin_oe_i, // high while the timer owns the pin
    output logic ext_pin_o, // external clock or event line
    output logic sub_tick_o, // one-cycle sub clock pulse
    output logic pin_level_o // level seen on the loaded pin
);
    logic [2:0] sub_div = 3'h0; // free sub clock divider
    initial begin
        ext_pin_o = 1'b0;
        sub_tick_o = 1'b0;
    end
    // sub clock runs free, one pulse every eight cycles
    always @(posedge clk_i) begin
        sub_div <= sub_div + 3'h1;
        sub_tick_o <= (sub_div == 3'h7);
    end
    // pull-down load: a released pin reads low, not its last level
    assign pin_level_o = pin_oe_i ? pin_drive_i : 1'b0;
    // n whole pulses, each with one rising and one falling edge; half sets prompt or slow
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge clk_i);
            ext_pin_o <= 1'b1;
            repeat (half) @(posedge clk_i);
            ext_pin_o <= 1'b0;
        end
    endtask
endmodule // ctm_pin_partner

// file: verif/ctm_top_tb.sv
// self-checking bench of the compact timer: registers, event counting, compare output, pwm
`timescale 1ns/1ps
module ctm_top_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} ctm_row_s; // d: write data or expected read
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_o;
    logic ack_o, ext_pin, sub_tick, claimed, out_pin, out_oe, irq_a, irq_p, pin_level;
    logic [4:0] route; // pin route outputs
    logic [7:0] rd; // last read byte
    logic [9:0] cm [4]; // compare rows: ctrl1, level after on, level after match
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int highs; // high pin cycles in one period
    logic [15:0] v0, v1; // count before and after a rate window
    logic [7:0] rate_exp [6]; // ticks per 64 clocks for select codes 0 to 5
    ctm_row_s rows [18];

    ctm_top u_ctm_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .timer_ext_clock_pin_i(ext_pin),
        .sub_clock_tick_i(sub_tick), .ext_pin_claimed_o(claimed), .timer_output_pin_o(out_pin),
        .timer_output_oe_o(out_oe), .pin_route_o(route), .irq_a_o(irq_a), .irq_p_o(irq_p));
    ctm_pin_partner u_ctm_pin_partner (.clk_i(clk_i), .pin_drive_i(out_pin), .pin_oe_i(out_oe),
        .ext_pin_o(ext_pin), .sub_tick_o(sub_tick), .pin_level_o(pin_level));

    // free clock, 50 ns period
    always #25 clk_i = ~clk_i;

    // hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; held until ack is sampled, released after it
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        sel_i <= 4'h1;
        // no local limit: only the bench hang guard ends a missing answer
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // count pair read high first, so low comes from the captured buffer
    task automatic cnt(input logic [15:0] e);
        wb(1'b0, ctm_pkg::OFF_CNT_HI, 8'h00);
        chk8(rd, e[15:8]);
        wb(1'b0, ctm_pkg::OFF_CNT_LO, 8'h00);
        chk8(rd, e[7:0]);
    endtask
    // count pair fetched in the legal order, for rate windows
    task automatic cntv(output logic [15:0] v);
        wb(1'b0, ctm_pkg::OFF_CNT_HI, 8'h00);
        v[15:8] = rd;
        wb(1'b0, ctm_pkg::OFF_CNT_LO, 8'h00);
        v[7:0] = rd;
    endtask
    task automatic end_of_test;
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        rows = '{'{1'b0, ctm_pkg::OFF_PIN_ROUTE, 8'h00}, '{1'b0, ctm_pkg::OFF_CTRL0, 8'h00},
            '{1'b0, ctm_pkg::OFF_CTRL1, 8'h00}, '{1'b0, ctm_pkg::OFF_CNT_HI, 8'h00},
            '{1'b0, ctm_pkg::OFF_CNT_LO, 8'h00}, '{1'b0, ctm_pkg::OFF_CMPA_HI, 8'h00},
            '{1'b0, ctm_pkg::OFF_CMPA_LO, 8'h00}, '{1'b1, ctm_pkg::OFF_PIN_ROUTE, 8'h1f},
            '{1'b0, ctm_pkg::OFF_PIN_ROUTE, 8'h1f}, '{1'b1, ctm_pkg::OFF_CNT_HI, 8'h55},
            '{1'b0, ctm_pkg::OFF_CNT_HI, 8'h00}, '{1'b1, ctm_pkg::OFF_CMPA_LO, 8'h34},
            '{1'b1, ctm_pkg::OFF_CMPA_HI, 8'h12}, '{1'b0, ctm_pkg::OFF_CMPA_HI, 8'h12},
            '{1'b0, ctm_pkg::OFF_CMPA_LO, 8'h34}, '{1'b1, ctm_pkg::OFF_CMPA_LO, 8'h77},
            '{1'b0, ctm_pkg::OFF_CMPA_HI, 8'h12}, '{1'b0, ctm_pkg::OFF_CMPA_LO, 8'h34}};
        cm = '{{8'h09, 2'b11}, {8'h19, 2'b10}, {8'h21, 2'b01}, {8'h31, 2'b01}};
        rate_exp = '{8'h10, 8'h40, 8'h04, 8'h01, 8'h08, 8'h00};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // register table walk; last rows show a lone low write leaves the pair alone
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk8(rd, rows[i].d);
        end
        wb(1'b0, 8'h24, 8'h00);
        chk8(rd, 8'h00);
        chk8({3'h0, route}, 8'h1f);
        chk1(out_oe, 1'b1);
        // event counting on the external pin
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'hc0);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h68);
        u_ctm_pin_partner.pulses(5, 2);
        chk1(claimed, 1'b1);
        cnt(16'h0005);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h78);
        u_ctm_pin_partner.pulses(3, 3);
        cnt(16'h0008);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h58);
        u_ctm_pin_partner.pulses(3, 2);
        chk1(claimed, 1'b0);
        cnt(16'h0008);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'he8);
        u_ctm_pin_partner.pulses(3, 2);
        cnt(16'h0008);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h68);
        u_ctm_pin_partner.pulses(2, 1);
        cnt(16'h000a);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h60);
        u_ctm_pin_partner.pulses(2, 2);
        cnt(16'h000a);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h68);
        cnt(16'h0000);
        // compare output codes, counter cleared by the A match
        wb(1'b1, ctm_pkg::OFF_CMPA_LO, 8'h03);
        wb(1'b1, ctm_pkg::OFF_CMPA_HI, 8'h00);
        foreach (cm[i]) begin
            wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h60);
            wb(1'b1, ctm_pkg::OFF_CTRL1, cm[i][9:2]);
            wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h68);
            wb(1'b1, ctm_pkg::OFF_FLAGS, 8'h03);
            chk1(pin_level, cm[i][1]);
            u_ctm_pin_partner.pulses(3, 2);
            cnt(16'h0000);
            chk1(pin_level, cm[i][0]);
            chk1(irq_a, 1'b1);
            chk1(irq_p, 1'b0);
        end
        wb(1'b1, ctm_pkg::OFF_FLAGS, 8'h01);
        chk1(irq_a, 1'b0);
        // pwm: period 256 system clocks, duty 64, active high
        wb(1'b1, ctm_pkg::OFF_CMPA_LO, 8'h40);
        wb(1'b1, ctm_pkg::OFF_CMPA_HI, 8'h00);
        wb(1'b1, ctm_pkg::OFF_PERIOD, 8'h01);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h10);
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'ha8);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h18);
        repeat (300) @(posedge clk_i);
        highs = 0;
        repeat (256) begin
            @(posedge clk_i);
            highs += int'(pin_level);
        end
        chk8(8'(highs), 8'h40);
        chk1(irq_p, 1'b1);
        // swapped roles, inverted: A sets a 512-clock period, P a 256-clock duty
        wb(1'b1, ctm_pkg::OFF_CMPA_LO, 8'h00);
        wb(1'b1, ctm_pkg::OFF_CMPA_HI, 8'h02);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h10);
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'hae);
        wb(1'b1, ctm_pkg::OFF_CTRL0, 8'h18);
        repeat (600) @(posedge clk_i);
        highs = 0;
        repeat (512) begin
            @(posedge clk_i);
            highs += int'(pin_level);
        end
        chk8(8'(highs >> 8), 8'h01);
        chk8(8'(highs), 8'h00);
        // static pwm levels, then undefined mode; the pin reads low, high, low, and stays low once released
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'h88);
        @(posedge clk_i);
        chk1(pin_level, 1'b0);
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'h98);
        @(posedge clk_i);
        chk1(pin_level, 1'b1);
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'h4c);
        @(posedge clk_i);
        chk1(out_pin, 1'b0);
        wb(1'b1, ctm_pkg::OFF_PIN_ROUTE, 8'h1e);
        repeat (3) @(posedge clk_i);
        chk1(out_oe, 1'b0);
        chk1(pin_level, 1'b0);
        // internal rates over 64 clocks; a multiple of every divider, so phase does not matter
        wb(1'b1, ctm_pkg::OFF_PERIOD, 8'h00);
        wb(1'b1, ctm_pkg::OFF_CTRL1, 8'hc0);
        for (int c = 0; c < 6; c++) begin
            wb(1'b1, ctm_pkg::OFF_CTRL0, {1'b0, 3'(c), 4'h8});
            cntv(v0);
            repeat (58) @(posedge clk_i);
            cntv(v1);
            chk8(8'(v1 - v0), rate_exp[c]);
        end
        end_of_test();
    end
endmodule // ctm_top_tb
